// *** include/power_mode_defines.vh ***
// constants for the power mode and clock source controller
`ifndef POWER_MODE_DEFINES_VH
`define POWER_MODE_DEFINES_VH

// register byte offsets
`define PMC_OFFSET 12'h000
`define HALT_OFFSET 12'h004
`define STATUS_OFFSET 12'h008

// power mode control fields
`define PMC_RESET 8'h40
`define PMC_LOW_OSC_BIT 7
`define PMC_HIGH_OSC_BIT 6
`define PMC_TIMER_SLOW_BIT 5
`define PMC_CORE_SLOW_BIT 4
`define PMC_RSVD_BIT 3
`define PMC_WINDOW_MSB 2
`define PMC_WINDOW_LSB 0

// legal upper nibbles
`define NIB_HIGH 4'h4
`define NIB_HIGH_DUAL 4'hc
`define NIB_DUAL 4'he
`define NIB_DUAL_LOW 4'hf
`define NIB_LOW 4'hb

// halt request field
`define HALT_REQ_BIT 7

// timing
`define INST_DIV 3'h5
`define INST_MID 3'h2
`define TIMER_W 9
`define STARTUP_LOAD 9'h100
`define IRESET_HIGH 5'h0f

`endif

// *** design/idle_down_counter.v ***
// loadable down counter with a registered underflow pulse
`timescale 1ns/1ns
module idle_down_counter #(
  parameter WIDTH = 9
) (
  input wire clk_i,
  input wire reset_i,
  input wire load_i,
  input wire [WIDTH-1:0] load_value_i,
  input wire dec_i,
  output reg [WIDTH-1:0] count_o,
  output reg underflow_o
);

  // ==========================================================
  // count and underflow
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o <= {WIDTH{1'b0}};
      underflow_o <= 1'b0;
    end else if (load_i) begin
      count_o <= load_value_i;
      underflow_o <= 1'b0;
    end else if (dec_i) begin
      count_o <= count_o - {{(WIDTH-1){1'b0}}, 1'b1};
      underflow_o <= (count_o == {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      underflow_o <= 1'b0;
    end
  end

endmodule // idle_down_counter

// *** design/power_mode_control.v ***
// power mode, clock source and halt controller with apb registers
//
// What this block does
// - bit 7 turns the low-speed oscillator on; off when zero.
// - bit 6 turns the high-speed oscillator on; off when zero.
// - bit 5 puts the idle timer on the low-speed clock.
// - bit 4 puts the core on the low-speed clock.
// - every reset loads the control register with 40 hex.
// - timer select zero with core select one forces low-speed mode.
// - bits 2 to 0 go out as the idle window select.
// - upper nibble outside the five legal values resets the device.
// - that reset presets the idle timer to 00Fx, 240 to 255 cycles.
// - every reset enters high-speed mode.
// - low-speed to high-speed must pass through dual-clock mode.
// - writing 1 to halt bit 7 halts mid next instruction cycle.
// - halt stops the core clock and the high-speed oscillator.
// - low reset pin leaves halt and restarts execution at 0000H.
// - a rising wake-up pin transition leaves halt.
// - wake-up always applies the start-up delay, option bit or not.
// - start-up loads 256, counts per five clocks, clocks run at underflow.
// - the start-up count only advances while amplitude is good.
// - with halt disabled every halt request is ignored.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "power_mode_defines.vh"
module power_mode_control #(
  parameter ADDR_W = 12
) (
  input wire clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire reset_pin_n_i,
  input wire wake_pin_i,
  input wire osc_amp_ok_i,
  input wire halt_disable_i,
  input wire startup_delay_option_i,
  output reg low_osc_on_o,
  output reg high_osc_on_o,
  output reg timer_clock_slow_sel_o,
  output reg core_clock_slow_sel_o,
  output reg [2:0] idle_window_sel_o,
  output reg core_clock_en_o,
  output reg core_reset_o,
  output reg halted_o,
  output reg internal_reset_o
);

  // ==========================================================
  // states
  localparam [2:0] ST_RUN = 3'b000;
  localparam [2:0] ST_HALT_ARM = 3'b001;
  localparam [2:0] ST_HALT_MID = 3'b010;
  localparam [2:0] ST_HALTED = 3'b011;
  localparam [2:0] ST_STARTUP = 3'b100;
  localparam [2:0] ST_IRESET = 3'b101;

  // ==========================================================
  // pin synchronisers
  reg rst_pin_s1_reg;
  reg rst_pin_s2_reg;
  reg wake_s1_reg;
  reg wake_s2_reg;
  reg wake_s3_reg;
  reg amp_s1_reg;
  reg amp_s2_reg;
  reg hdis_s1_reg;
  reg hdis_s2_reg;
  reg dly_s1_reg;
  reg dly_s2_reg;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_pin_s1_reg <= 1'b1;
      rst_pin_s2_reg <= 1'b1;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
      amp_s1_reg <= 1'b0;
      amp_s2_reg <= 1'b0;
      hdis_s1_reg <= 1'b0;
      hdis_s2_reg <= 1'b0;
      dly_s1_reg <= 1'b0;
      dly_s2_reg <= 1'b0;
    end else begin
      rst_pin_s1_reg <= reset_pin_n_i;
      rst_pin_s2_reg <= rst_pin_s1_reg;
      wake_s1_reg <= wake_pin_i;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
      amp_s1_reg <= osc_amp_ok_i;
      amp_s2_reg <= amp_s1_reg;
      hdis_s1_reg <= halt_disable_i;
      hdis_s2_reg <= hdis_s1_reg;
      dly_s1_reg <= startup_delay_option_i;
      dly_s2_reg <= dly_s1_reg;
    end
  end

  wire pin_reset;
  wire wake_edge;
  assign pin_reset = ~rst_pin_s2_reg;
  assign wake_edge = wake_s2_reg & ~wake_s3_reg;

  // ==========================================================
  // instruction cycle prescaler, five clocks per cycle
  reg [2:0] presc_reg;
  wire inst_tick;
  wire inst_mid;
  assign inst_tick = (presc_reg == `INST_DIV - 3'h1);
  assign inst_mid = (presc_reg == `INST_MID);

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      presc_reg <= 3'h0;
    end else if (inst_tick) begin
      presc_reg <= 3'h0;
    end else begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  // ==========================================================
  // apb decode
  wire setup_phase;
  wire access_done;
  wire bus_write;
  wire sel_pmc;
  wire sel_halt;
  wire sel_status;
  wire mapped;
  assign setup_phase = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_o;
  assign bus_write = access_done & pwrite_i;
  assign sel_pmc = (paddr_i == `PMC_OFFSET);
  assign sel_halt = (paddr_i == `HALT_OFFSET);
  assign sel_status = (paddr_i == `STATUS_OFFSET);
  assign mapped = sel_pmc | sel_halt | sel_status;

  // ==========================================================
  // write data fields
  wire [7:0] pmc_wdata;
  wire halt_bit;
  wire wr_timer_slow;
  wire wr_core_slow;
  assign pmc_wdata = pwdata_i[`PMC_LOW_OSC_BIT:`PMC_WINDOW_LSB];
  assign halt_bit = pwdata_i[`HALT_REQ_BIT];
  assign wr_timer_slow = pwdata_i[`PMC_TIMER_SLOW_BIT];
  assign wr_core_slow = pwdata_i[`PMC_CORE_SLOW_BIT];

  // ==========================================================
  // mode state and control register
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] pmc_reg;
  reg [7:0] pmc_next;
  reg timer_load;
  reg [`TIMER_W-1:0] timer_load_value;
  reg timer_dec;
  wire [`TIMER_W-1:0] timer_count;
  wire timer_underflow;
  wire [3:0] nibble;
  wire nibble_legal;
  wire halt_req;
  wire pmc_write;
  wire low_to_high;
  reg [7:0] status_byte;

  assign nibble = pmc_reg[7:4];
  assign nibble_legal = (nibble == `NIB_HIGH) | (nibble == `NIB_HIGH_DUAL) |
                        (nibble == `NIB_DUAL) | (nibble == `NIB_DUAL_LOW) |
                        (nibble == `NIB_LOW);
  assign halt_req = bus_write & sel_halt & halt_bit & ~hdis_s2_reg;
  assign pmc_write = bus_write & sel_pmc;
  // core and timer both on the slow clock, write would drop both at once
  assign low_to_high = pmc_reg[`PMC_TIMER_SLOW_BIT] & pmc_reg[`PMC_CORE_SLOW_BIT] &
                       ~wr_timer_slow & ~wr_core_slow;

  always @* begin
    state_next = state_reg;
    pmc_next = pmc_reg;
    timer_load = 1'b0;
    timer_load_value = `STARTUP_LOAD;
    timer_dec = 1'b0;
    case (state_reg)
      ST_RUN: begin
        timer_dec = inst_tick;
        if (!nibble_legal) begin
          state_next = ST_IRESET;
          pmc_next = `PMC_RESET;
          timer_load = 1'b1;
          timer_load_value = {`IRESET_HIGH, timer_count[3:0]};
        end else if (halt_req) begin
          state_next = ST_HALT_ARM;
        end else if (pmc_write && !low_to_high) begin
          pmc_next = pmc_wdata;
        end
      end
      ST_HALT_ARM: begin
        timer_dec = inst_tick;
        if (inst_tick) begin
          state_next = ST_HALT_MID;
        end
      end
      ST_HALT_MID: begin
        timer_dec = inst_tick;
        if (inst_mid) begin
          state_next = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (wake_edge) begin
          state_next = ST_STARTUP;
          timer_load = 1'b1;
          timer_load_value = `STARTUP_LOAD;
        end
      end
      ST_STARTUP: begin
        timer_dec = inst_tick & amp_s2_reg;
        if (timer_underflow) begin
          state_next = ST_RUN;
        end
      end
      ST_IRESET: begin
        timer_dec = inst_tick;
        if (timer_underflow) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_RUN;
      pmc_reg <= `PMC_RESET;
    end else if (pin_reset) begin
      state_reg <= ST_RUN;
      pmc_reg <= `PMC_RESET;
    end else begin
      state_reg <= state_next;
      pmc_reg <= pmc_next;
    end
  end

  // ==========================================================
  // idle timer
  idle_down_counter #(
    .WIDTH(`TIMER_W)
  ) idle_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(timer_load),
    .load_value_i(timer_load_value),
    .dec_i(timer_dec),
    .count_o(timer_count),
    .underflow_o(timer_underflow)
  );

  // ==========================================================
  // state decode
  wire st_run;
  wire st_arm;
  wire st_mid;
  wire st_startup;
  wire st_ireset;
  wire executing;
  assign st_run = (state_reg == ST_RUN);
  assign st_arm = (state_reg == ST_HALT_ARM);
  assign st_mid = (state_reg == ST_HALT_MID);
  assign st_startup = (state_reg == ST_STARTUP);
  assign st_ireset = (state_reg == ST_IRESET);
  assign executing = st_run | st_arm | st_mid;

  // ==========================================================
  // clock and oscillator controls
  wire in_halt;
  wire forced_slow;
  assign in_halt = (state_reg == ST_HALTED);
  assign forced_slow = pmc_reg[`PMC_CORE_SLOW_BIT] & ~pmc_reg[`PMC_TIMER_SLOW_BIT];

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_osc_on_o <= 1'b0;
      high_osc_on_o <= 1'b1;
      timer_clock_slow_sel_o <= 1'b0;
      core_clock_slow_sel_o <= 1'b0;
      idle_window_sel_o <= 3'h0;
      core_clock_en_o <= 1'b0;
      core_reset_o <= 1'b1;
      halted_o <= 1'b0;
      internal_reset_o <= 1'b0;
    end else begin
      low_osc_on_o <= pmc_reg[`PMC_LOW_OSC_BIT];
      high_osc_on_o <= pmc_reg[`PMC_HIGH_OSC_BIT] & ~in_halt;
      timer_clock_slow_sel_o <= pmc_reg[`PMC_TIMER_SLOW_BIT] | forced_slow;
      core_clock_slow_sel_o <= pmc_reg[`PMC_CORE_SLOW_BIT];
      idle_window_sel_o <= pmc_reg[`PMC_WINDOW_MSB:`PMC_WINDOW_LSB];
      core_clock_en_o <= ~pin_reset & executing;
      core_reset_o <= pin_reset | st_ireset;
      halted_o <= in_halt | st_startup;
      internal_reset_o <= st_ireset;
    end
  end

  // ==========================================================
  // apb answer, one cycle after setup
  always @* begin
    status_byte = {1'b0, dly_s2_reg, hdis_s2_reg, core_clock_en_o, 1'b0, state_reg};
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      pready_o <= 1'b1;
      pslverr_o <= ~mapped;
      if (sel_pmc) begin
        prdata_o <= {24'h000000, pmc_reg};
      end else if (sel_status) begin
        prdata_o <= {24'h000000, status_byte};
      end else begin
        prdata_o <= 32'h00000000;
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule // power_mode_control

// *** dv/osc_partner.sv ***
// high-speed oscillator amplitude model
`timescale 1ns/1ns
module osc_partner #(
  parameter SETTLE = 40
) (
  input wire clk_i,
  input wire reset_i,
  input wire high_osc_on_i,
  output logic amp_ok_o
);
  int cnt;
  // =====
  // amplitude builds after enable
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i || !high_osc_on_i) begin
      cnt <= 0;
      amp_ok_o <= 1'b0;
    end else if (cnt < SETTLE) begin
      cnt <= cnt + 1;
    end else begin
      amp_ok_o <= 1'b1;
    end
  end
endmodule // osc_partner

// *** dv/power_mode_control_asserts.sv ***
// port checker for the power mode controller
`timescale 1ns/1ns
module power_mode_control_asserts #(
  parameter ADDR_W = 12
) (
  input wire clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire reset_pin_n_i,
  input wire osc_amp_ok_i,
  input wire halt_disable_i,
  input wire low_osc_on_o,
  input wire high_osc_on_o,
  input wire timer_clock_slow_sel_o,
  input wire core_clock_slow_sel_o,
  input wire [2:0] idle_window_sel_o,
  input wire core_clock_en_o,
  input wire core_reset_o,
  input wire halted_o,
  input wire internal_reset_o
);
  // =====
  // helpers
  wire acc = psel_i && penable_i && pready_o && pwrite_i;
  wire wr_ctl = acc && paddr_i == 12'h000 && core_clock_en_o;
  wire wr_halt = acc && paddr_i == 12'h004 && pwdata_i[7];
  wire [3:0] nib = pwdata_i[7:4];
  wire legal = nib == 4'h4 || nib == 4'hc || nib == 4'he || nib == 4'hf || nib == 4'hb;
  logic [11:0] ir_cnt;
  logic [11:0] amp_cnt;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ir_cnt <= 12'h000;
      amp_cnt <= 12'h000;
    end else begin
      ir_cnt <= internal_reset_o ? ir_cnt + 12'h001 : 12'h000;
      amp_cnt <= !halted_o ? 12'h000 : amp_cnt + {11'h000, osc_amp_ok_i};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // =====
  // properties
  AST_PIN_RESET: assert property (!reset_pin_n_i [*5] |-> core_reset_o && !halted_o
    && !core_clock_en_o && high_osc_on_o && !low_osc_on_o) else $error("pin reset state");
  AST_LOW_OSC: assert property ($rose(low_osc_on_o) |-> $past(wr_ctl && pwdata_i[7], 2))
    else $error("low osc without write");
  AST_WINDOW: assert property (wr_ctl && pwdata_i[5] |->
    ##2 idle_window_sel_o == $past(pwdata_i[2:0], 2)) else $error("window select");
  AST_FORCE_LOW: assert property (core_clock_slow_sel_o |-> timer_clock_slow_sel_o)
    else $error("core slow without timer slow");
  AST_ILLEGAL: assert property (wr_ctl && !legal |-> ##[1:4] internal_reset_o)
    else $error("no illegal reset");
  AST_ILLEGAL_LEN: assert property ($fell(internal_reset_o) |->
    ir_cnt >= 12'h4a6 && ir_cnt <= 12'h514) else $error("illegal reset length");
  AST_HALT_ENTRY: assert property (wr_halt && !halt_disable_i && core_clock_en_o
    |-> ##[2:14] halted_o) else $error("halt not entered");
  AST_HALT_STOP: assert property (halted_o |-> !core_clock_en_o
    && (!$rose(halted_o) || !high_osc_on_o)) else $error("clocks run in halt");
  AST_HALT_DIS: assert property (wr_halt && halt_disable_i |-> ##3 !halted_o [*8])
    else $error("halt not ignored");
  AST_STARTUP: assert property ($fell(halted_o) && reset_pin_n_i |->
    amp_cnt >= 12'h4f6 && amp_cnt <= 12'h514) else $error("startup length");
endmodule // power_mode_control_asserts
bind power_mode_control power_mode_control_asserts #(
  .ADDR_W(ADDR_W)
) asserts_inst (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pready_o(pready_o),
  .reset_pin_n_i(reset_pin_n_i),
  .osc_amp_ok_i(osc_amp_ok_i),
  .halt_disable_i(halt_disable_i),
  .low_osc_on_o(low_osc_on_o),
  .high_osc_on_o(high_osc_on_o),
  .timer_clock_slow_sel_o(timer_clock_slow_sel_o),
  .core_clock_slow_sel_o(core_clock_slow_sel_o),
  .idle_window_sel_o(idle_window_sel_o),
  .core_clock_en_o(core_clock_en_o),
  .core_reset_o(core_reset_o),
  .halted_o(halted_o),
  .internal_reset_o(internal_reset_o)
);

// *** dv/dual_clock_power_mode_control_tb_top.sv ***
// self-checking bench for the power mode controller
`timescale 1ns/1ns
module dual_clock_power_mode_control_tb_top;
  localparam int SETTLE = 40;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic reset_pin_n_i = 1'b1;
  logic wake_pin_i = 1'b0;
  logic halt_disable_i = 1'b0;
  logic startup_delay_option_i = 1'b0;
  wire osc_amp_ok_i, pready_o, pslverr_o, low_osc_on_o, high_osc_on_o;
  wire timer_clock_slow_sel_o, core_clock_slow_sel_o, core_clock_en_o;
  wire core_reset_o, halted_o, internal_reset_o;
  wire [2:0] idle_window_sel_o;
  wire [31:0] prdata_o;
  wire [7:0] outs = {low_osc_on_o, high_osc_on_o, timer_clock_slow_sel_o,
    core_clock_slow_sel_o, 1'b0, idle_window_sel_o};
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] rows [9] = '{16'hc1c1, 16'he2e2, 16'hf3f3, 16'hb4b4, 16'h40b4, 16'hf5f5,
    16'he6e6, 16'hc7c7, 16'h4040};
  // =====
  // clock, parts and tasks
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  osc_partner #(.SETTLE(SETTLE)) osc_partner_inst (.clk_i, .reset_i,
    .high_osc_on_i(high_osc_on_o), .amp_ok_o(osc_amp_ok_i));
  power_mode_control power_mode_control_inst (.clk_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .reset_pin_n_i,
    .wake_pin_i, .osc_amp_ok_i, .halt_disable_i, .startup_delay_option_i,
    .low_osc_on_o, .high_osc_on_o, .timer_clock_slow_sel_o, .core_clock_slow_sel_o,
    .idle_window_sel_o, .core_clock_en_o, .core_reset_o, .halted_o, .internal_reset_o);
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(negedge clk_i);
    while (pready_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (pready_o !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] pready expected 1 seen %b", pready_o);
    end
    rd = prdata_o;
    err = pslverr_o;
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
  // =====
  // tests
  initial begin
    int t;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctl reset", 32'h40, rd);
    chk("outs reset", 32'h40, {24'h0, outs});
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {24'h0, rows[i][15:8]});
      repeat (10) @(posedge clk_i);
      chk("outs", {24'h0, rows[i][7:0]}, {24'h0, outs});
      apb(1'b0, 12'h000, 32'h0);
      chk("ctl", {24'h0, rows[i][7:0]}, rd);
    end
    $display("mode test done");
    apb(1'b1, 12'h000, 32'hd0);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("forced slow", 32'h3, {30'h0, timer_clock_slow_sel_o, core_clock_slow_sel_o});
    for (t = 0; internal_reset_o !== 1'b1 && t < 10; t++) @(posedge clk_i);
    for (t = 0; internal_reset_o === 1'b1 && t < 2000; t++) @(posedge clk_i);
    chk("ireset span", 32'h1, {31'h0, t >= 1190 && t <= 1300});
    apb(1'b0, 12'h000, 32'h0);
    chk("ctl reload", 32'h40, rd);
    $display("illegal test done");
    startup_delay_option_i <= 1'b1;
    apb(1'b1, 12'h004, 32'h80);
    for (t = 0; halted_o !== 1'b1 && t < 20; t++) @(posedge clk_i);
    @(posedge clk_i);
    chk("halt", 32'h4, {29'h0, halted_o, high_osc_on_o, core_clock_en_o});
    wake_pin_i <= 1'b1;
    for (t = 0; halted_o !== 1'b0 && t < 3000; t++) @(posedge clk_i);
    chk("startup", 32'h1, {31'h0, t >= 1280 + SETTLE && t < 1400});
    wake_pin_i <= 1'b0;
    $display("wake test done");
    apb(1'b1, 12'h000, 32'hc1);
    repeat (10) @(posedge clk_i);
    apb(1'b1, 12'h004, 32'h80);
    repeat (20) @(posedge clk_i);
    reset_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("pin reset", 32'h1, {30'h0, halted_o, core_reset_o});
    reset_pin_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctl pin", 32'h40, rd);
    $display("pin test done");
    halt_disable_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    apb(1'b1, 12'h004, 32'h80);
    repeat (20) @(posedge clk_i);
    chk("halt off", 32'h1, {30'h0, halted_o, core_clock_en_o});
    apb(1'b0, 12'h008, 32'h0);
    chk("status", 32'h70, rd);
    $display("disable test done");
    conclude();
  end
endmodule // dual_clock_power_mode_control_tb_top
